// file: motor_estimator_status_map.svh
// Register indices, reset values and bus codes for the estimator status bank
`ifndef MOTOR_ESTIMATOR_STATUS_MAP_SVH
`define MOTOR_ESTIMATOR_STATUS_MAP_SVH

// Word indices; byte address is four times the index
`define MES_IDX_SPEED_STATE 11'h680
`define MES_IDX_SPEED_WORD 11'h68a
`define MES_IDX_POS_STATE 11'h6be
`define MES_IDX_POS_ANGLE 11'h702
`define MES_IDX_EMF_D 11'h748
`define MES_IDX_EMF_Q 11'h74a
`define MES_IDX_IRQ_STATUS 11'h7f0
`define MES_IDX_IRQ_MASK 11'h7f1

// Address field holding the word index
`define MES_IDX_HI 12
`define MES_IDX_LO 2
`define MES_ADDR_TOP 31
`define MES_ADDR_ZERO 19'h00000

`define MES_STATE_RST 16'h0000
`define MES_WORD_RST 32'h00000000
`define MES_EVENT_RST 4'h0
`define MES_STATE_PAD 16'h0000
`define MES_EVENT_PAD 28'h0000000

// Event bit positions in the interrupt status and mask words
`define MES_EV_SPEED_DONE 0
`define MES_EV_SPEED_FAULT 1
`define MES_EV_POS_DONE 2
`define MES_EV_POS_FAULT 3
`define MES_EVENT_TOP 3

`define MES_RESP_OKAY 2'h0
`define MES_RESP_SLVERR 2'h2

`endif

// file: motor_estimator_status_pkg.sv
// Types shared by the estimator status register bank
package motor_estimator_status_pkg;

  typedef logic [15:0] state_code_t;
  typedef logic [31:0] fixed_word_t;
  typedef logic [3:0] event_vec_t;

  typedef enum logic [15:0] {
    SPEED_DETECT_INIT = 16'h0000,
    SPEED_DETECT_STOP_CHECK = 16'h0001,
    SPEED_DETECT_ESTIM_INIT = 16'h0002,
    SPEED_DETECT_RUN_CHECK = 16'h0003,
    SPEED_DETECT_DIR_CHECK = 16'h0004,
    SPEED_DETECT_DONE = 16'h0005,
    SPEED_DETECT_FAULT = 16'h0006
  } speed_detect_state_t;

  typedef enum logic [15:0] {
    POS_DETECT_INIT = 16'h0000,
    POS_DETECT_VECTOR_CONFIG = 16'h0001,
    POS_DETECT_RUN = 16'h0002,
    POS_DETECT_SLOW_RISE = 16'h0003,
    POS_DETECT_SLOW_FALL = 16'h0004,
    POS_DETECT_DECAY_WAIT = 16'h0005,
    POS_DETECT_GET_TIMES = 16'h0006,
    POS_DETECT_NEXT_VECTOR = 16'h0007,
    POS_DETECT_SECTOR_RISE = 16'h0008,
    POS_DETECT_ROTOR_POS = 16'h0009,
    POS_DETECT_ANGLE = 16'h000a,
    POS_DETECT_DONE = 16'h000b,
    POS_DETECT_FAULT = 16'h000c
  } position_detect_state_t;

endpackage : motor_estimator_status_pkg

// file: status_word_hold.sv
// One read-only status word, loaded only by the estimator
`timescale 1ns/100ps
module status_word_hold #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic refClk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] word_reg;

  // No bus path reaches this storage, so host writes cannot alter it
  always_ff @(posedge refClk) begin
    if (rst) begin
      word_reg <= RESET_VALUE;
    end else if (load) begin
      word_reg <= din;
    end
  end

  assign q = word_reg;
endmodule : status_word_hold

// file: event_flag_bank.sv
// Sticky event flags with write-one-to-clear and a masked level interrupt
`timescale 1ns/100ps
`include "motor_estimator_status_map.svh"
module event_flag_bank (
  input wire logic refClk,
  input wire logic rst,
  input wire motor_estimator_status_pkg::event_vec_t setEvents,
  input wire motor_estimator_status_pkg::event_vec_t clearBits,
  input wire logic clearEn,
  input wire motor_estimator_status_pkg::event_vec_t maskBits,
  output motor_estimator_status_pkg::event_vec_t flags,
  output logic irq
);
  import motor_estimator_status_pkg::*;

  event_vec_t flags_reg;
  event_vec_t flags_next;
  event_vec_t clearGate;
  logic irq_reg;
  logic irq_next;

  // Set is or-ed in last so an event in the clearing cycle survives
  assign clearGate = clearEn ? clearBits : `MES_EVENT_RST;
  assign flags_next = (flags_reg & ~clearGate) | setEvents;
  assign irq_next = |(flags_next & maskBits);

  always_ff @(posedge refClk) begin
    if (rst) begin
      flags_reg <= `MES_EVENT_RST;
      irq_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_reg <= irq_next;
    end
  end

  assign flags = flags_reg;
  assign irq = irq_reg;
endmodule : event_flag_bank

// file: motor_estimator_status_regs.sv
// Estimator status register bank behind an AXI4-Lite slave
`timescale 1ns/100ps
`include "motor_estimator_status_map.svh"

module motor_estimator_status_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire motor_estimator_status_pkg::state_code_t speedStateIn,
  input wire logic speedStateLoad,
  input wire motor_estimator_status_pkg::fixed_word_t speedWordIn,
  input wire logic speedWordLoad,
  input wire motor_estimator_status_pkg::state_code_t posStateIn,
  input wire logic posStateLoad,
  input wire motor_estimator_status_pkg::fixed_word_t posAngleIn,
  input wire logic posAngleLoad,
  input wire motor_estimator_status_pkg::fixed_word_t emfDirectIn,
  input wire logic emfDirectLoad,
  input wire motor_estimator_status_pkg::fixed_word_t emfQuadIn,
  input wire logic emfQuadLoad,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  import motor_estimator_status_pkg::*;

  state_code_t speedStateQ;
  fixed_word_t speedWordQ;
  state_code_t posStateQ;
  fixed_word_t posAngleQ;
  fixed_word_t emfDirectQ;
  fixed_word_t emfQuadQ;

  status_word_hold #(.WIDTH(16), .RESET_VALUE(`MES_STATE_RST)) speedStateHold (
    .refClk(ref_clk), .rst(rst), .load(speedStateLoad), .din(speedStateIn), .q(speedStateQ)
  );
  status_word_hold #(.WIDTH(32), .RESET_VALUE(`MES_WORD_RST)) speedWordHold (
    .refClk(ref_clk), .rst(rst), .load(speedWordLoad), .din(speedWordIn), .q(speedWordQ)
  );
  status_word_hold #(.WIDTH(16), .RESET_VALUE(`MES_STATE_RST)) posStateHold (
    .refClk(ref_clk), .rst(rst), .load(posStateLoad), .din(posStateIn), .q(posStateQ)
  );
  status_word_hold #(.WIDTH(32), .RESET_VALUE(`MES_WORD_RST)) posAngleHold (
    .refClk(ref_clk), .rst(rst), .load(posAngleLoad), .din(posAngleIn), .q(posAngleQ)
  );
  status_word_hold #(.WIDTH(32), .RESET_VALUE(`MES_WORD_RST)) emfDirectHold (
    .refClk(ref_clk), .rst(rst), .load(emfDirectLoad), .din(emfDirectIn), .q(emfDirectQ)
  );
  status_word_hold #(.WIDTH(32), .RESET_VALUE(`MES_WORD_RST)) emfQuadHold (
    .refClk(ref_clk), .rst(rst), .load(emfQuadLoad), .din(emfQuadIn), .q(emfQuadQ)
  );

  // Sequencer completion and fault codes raise interrupt events
  event_vec_t setEvents;
  assign setEvents[`MES_EV_SPEED_DONE] =
    speedStateLoad && (speedStateIn == state_code_t'(SPEED_DETECT_DONE));
  assign setEvents[`MES_EV_SPEED_FAULT] =
    speedStateLoad && (speedStateIn == state_code_t'(SPEED_DETECT_FAULT));
  assign setEvents[`MES_EV_POS_DONE] =
    posStateLoad && (posStateIn == state_code_t'(POS_DETECT_DONE));
  assign setEvents[`MES_EV_POS_FAULT] =
    posStateLoad && (posStateIn == state_code_t'(POS_DETECT_FAULT));

  // Write channel: address and data may arrive in either order
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic awHeld_reg;
  logic awHeld_next;
  logic wHeld_reg;
  logic wHeld_next;
  logic [31:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  wire awTake = awvalid && awready_reg;
  wire wTake = wvalid && wready_reg;
  wire haveAw = awHeld_reg || awTake;
  wire haveW = wHeld_reg || wTake;
  wire doWrite = haveAw && haveW;
  wire [31:0] writeAddr = awHeld_reg ? awAddr_reg : awaddr;
  wire [31:0] writeData = wHeld_reg ? wData_reg : wdata;
  wire [3:0] writeStrb = wHeld_reg ? wStrb_reg : wstrb;
  wire [10:0] writeIdx = writeAddr[`MES_IDX_HI:`MES_IDX_LO];
  wire writeHigh = writeAddr[`MES_ADDR_TOP:`MES_IDX_HI+1] == `MES_ADDR_ZERO;

  // Status words are decoded so that a write to them answers OKAY and does nothing
  wire wrHitRo = writeHigh && (
    (writeIdx == `MES_IDX_SPEED_STATE) || (writeIdx == `MES_IDX_SPEED_WORD) ||
    (writeIdx == `MES_IDX_POS_STATE) || (writeIdx == `MES_IDX_POS_ANGLE) ||
    (writeIdx == `MES_IDX_EMF_D) || (writeIdx == `MES_IDX_EMF_Q));
  wire wrHitStatus = writeHigh && (writeIdx == `MES_IDX_IRQ_STATUS);
  wire wrHitMask = writeHigh && (writeIdx == `MES_IDX_IRQ_MASK);
  wire wrHit = wrHitRo || wrHitStatus || wrHitMask;
  wire clearEn = doWrite && wrHitStatus && writeStrb[0];
  wire maskWrite = doWrite && wrHitMask && writeStrb[0];

  assign awHeld_next = haveAw && !doWrite;
  assign wHeld_next = haveW && !doWrite;
  assign bvalid_next = doWrite || (bvalid_reg && !bready);
  assign bresp_next = doWrite ? (wrHit ? `MES_RESP_OKAY : `MES_RESP_SLVERR) : bresp_reg;
  // Both readies stay low while a response waits: one write at a time
  assign awready_next = !awHeld_next && !bvalid_next;
  assign wready_next = !wHeld_next && !bvalid_next;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `MES_RESP_OKAY;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (awTake) begin
      awAddr_reg <= awaddr;
    end
    if (wTake) begin
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end
  end

  // Interrupt status and mask
  event_vec_t mask_reg;
  event_vec_t mask_next;
  event_vec_t eventFlags;
  logic irqLevel;

  assign mask_next = maskWrite ? writeData[`MES_EVENT_TOP:0] : mask_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_reg <= `MES_EVENT_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  event_flag_bank eventFlagsBank (
    .refClk(ref_clk),
    .rst(rst),
    .setEvents(setEvents),
    .clearBits(writeData[`MES_EVENT_TOP:0]),
    .clearEn(clearEn),
    .maskBits(mask_next),
    .flags(eventFlags),
    .irq(irqLevel)
  );

  // Read channel
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  wire arTake = arvalid && arready_reg;
  wire [10:0] readIdx = araddr[`MES_IDX_HI:`MES_IDX_LO];
  wire readHigh = araddr[`MES_ADDR_TOP:`MES_IDX_HI+1] == `MES_ADDR_ZERO;
  wire rdSpeedState = readHigh && (readIdx == `MES_IDX_SPEED_STATE);
  wire rdSpeedWord = readHigh && (readIdx == `MES_IDX_SPEED_WORD);
  wire rdPosState = readHigh && (readIdx == `MES_IDX_POS_STATE);
  wire rdPosAngle = readHigh && (readIdx == `MES_IDX_POS_ANGLE);
  wire rdEmfD = readHigh && (readIdx == `MES_IDX_EMF_D);
  wire rdEmfQ = readHigh && (readIdx == `MES_IDX_EMF_Q);
  wire rdStatus = readHigh && (readIdx == `MES_IDX_IRQ_STATUS);
  wire rdMask = readHigh && (readIdx == `MES_IDX_IRQ_MASK);
  wire rdHit = rdSpeedState || rdSpeedWord || rdPosState || rdPosAngle ||
    rdEmfD || rdEmfQ || rdStatus || rdMask;

  // Sixteen-bit codes sit in the low half, upper half reads zero
  wire [31:0] readMux =
    rdSpeedState ? {`MES_STATE_PAD, speedStateQ} :
    rdSpeedWord ? speedWordQ :
    rdPosState ? {`MES_STATE_PAD, posStateQ} :
    rdPosAngle ? posAngleQ :
    rdEmfD ? emfDirectQ :
    rdEmfQ ? emfQuadQ :
    rdStatus ? {`MES_EVENT_PAD, eventFlags} :
    rdMask ? {`MES_EVENT_PAD, mask_reg} :
    `MES_WORD_RST;

  assign rvalid_next = arTake || (rvalid_reg && !rready);
  assign arready_next = !rvalid_next;
  assign rdata_next = arTake ? readMux : rdata_reg;
  assign rresp_next = arTake ? (rdHit ? `MES_RESP_OKAY : `MES_RESP_SLVERR) : rresp_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `MES_WORD_RST;
      rresp_reg <= `MES_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = irqLevel;

  // Checks
  speed_state_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    arTake && rdSpeedState |=> rvalid && rdata == {`MES_STATE_PAD, $past(speedStateQ)})
    else $error("speed state read mismatch");

  speed_word_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    speedWordLoad ##1 arTake && rdSpeedWord && !speedWordLoad |=> rdata == $past(speedWordIn, 2))
    else $error("speed word not captured");

  pos_state_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    arTake && rdPosState |=> rdata[31:16] == `MES_STATE_PAD && rdata[15:0] == $past(posStateQ))
    else $error("position state read mismatch");

  pos_angle_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    posAngleLoad |=> posAngleQ == $past(posAngleIn))
    else $error("angle word not loaded");

  emf_direct_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    emfDirectLoad ##1 (arTake && rdEmfD && !emfDirectLoad) |=> rdata == $past(emfDirectIn, 2))
    else $error("direct estimate read mismatch");

  emf_quad_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    arTake && rdEmfQ |=> rvalid && rresp == `MES_RESP_OKAY && rdata == $past(emfQuadQ))
    else $error("quadrature estimate read mismatch");

  ro_write_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
    doWrite && wrHitRo && !speedStateLoad && !speedWordLoad && !emfQuadLoad |=>
      $stable(speedStateQ) && $stable(speedWordQ) && $stable(emfQuadQ) && bresp == `MES_RESP_OKAY)
    else $error("status word changed by host write");

  reset_zero_a: assert property (@(posedge ref_clk)
    $fell(rst) |-> speedStateQ == `MES_STATE_RST && speedWordQ == `MES_WORD_RST &&
      posStateQ == `MES_STATE_RST && posAngleQ == `MES_WORD_RST &&
      emfDirectQ == `MES_WORD_RST && emfQuadQ == `MES_WORD_RST)
    else $error("status word not zero after reset");

  read_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    rvalid && !rready |=> rvalid && $stable(rdata) && !arready)
    else $error("read response dropped before taken");

  write_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    awTake && wTake |=> bvalid ##1 (bvalid || awready))
    else $error("write response missing");

  write_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    bvalid && !bready |=> bvalid && $stable(bresp) && !awready && !wready)
    else $error("write response dropped before taken");

  event_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    |setEvents |=> (eventFlags & $past(setEvents)) == $past(setEvents))
    else $error("event flag not set");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    irq == |(eventFlags & mask_reg))
    else $error("interrupt level disagrees with flags");
endmodule : motor_estimator_status_regs

// file: motor_estimator_status_regs_bench.sv
// Self-checking bench for the estimator status register bank
`timescale 1ns/100ps
`include "motor_estimator_status_map.svh"
module motor_estimator_status_regs_bench;
  import motor_estimator_status_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  state_code_t speedStateIn = '0, posStateIn = '0;
  fixed_word_t speedWordIn = '0, posAngleIn = '0, emfDirectIn = '0, emfQuadIn = '0;
  logic speedStateLoad = 0, speedWordLoad = 0, posStateLoad = 0;
  logic posAngleLoad = 0, emfDirectLoad = 0, emfQuadLoad = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [3:0] strbSel = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  int errorCnt = 0, numChecks = 0, cycleCnt = 0;
  logic [31:0] lfsrReg = 32'hea9992c8;
  fixed_word_t expVal [6];
  localparam logic [10:0] IDX_TAB [6] = '{`MES_IDX_SPEED_STATE, `MES_IDX_SPEED_WORD,
    `MES_IDX_POS_STATE, `MES_IDX_POS_ANGLE, `MES_IDX_EMF_D, `MES_IDX_EMF_Q};

  motor_estimator_status_regs i_motor_estimator_status_regs (.ref_clk(ref_clk), .rst(rst),
    .speedStateIn(speedStateIn), .speedStateLoad(speedStateLoad),
    .speedWordIn(speedWordIn), .speedWordLoad(speedWordLoad),
    .posStateIn(posStateIn), .posStateLoad(posStateLoad),
    .posAngleIn(posAngleIn), .posAngleLoad(posAngleLoad),
    .emfDirectIn(emfDirectIn), .emfDirectLoad(emfDirectLoad),
    .emfQuadIn(emfQuadIn), .emfQuadLoad(emfQuadLoad),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));

  always #10 ref_clk = ~ref_clk;

  task automatic reportAndStop();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : reportAndStop

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 20000) begin
      errorCnt = errorCnt + 1;
      reportAndStop();
    end
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : lfsrNext

  function automatic logic [31:0] byteAddr(input logic [10:0] idx);
    return {19'h00000, idx, 2'b00};
  endfunction : byteAddr

  // Status codes sit in the low half; the upper half always reads zero
  function automatic fixed_word_t visible(input int sel, input fixed_word_t v);
    return (sel == 0 || sel == 2) ? {16'h0000, v[15:0]} : v;
  endfunction : visible

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    numChecks = numChecks + 1;
    if (seen !== expected) begin
      errorCnt = errorCnt + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check

  // Entered just after a rising edge; address and data offered together
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit awDone, wDone;
    awDone = 0;
    wDone = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= strbSel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Some responses are held off a cycle to exercise the slave's hold
    bready <= lfsrReg[4];
    forever begin
      @(posedge ref_clk);
      if (!awDone && awready) begin
        awDone = 1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1;
        wvalid <= 1'b0;
      end
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (bvalid) begin
        bready <= 1'b1;
      end
    end
    // Idle edge so a following call never re-raises ready in this step
    @(posedge ref_clk);
  endtask : axiWrite

  task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit arDone;
    arDone = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= lfsrReg[3];
    forever begin
      @(posedge ref_clk);
      if (!arDone && arready) begin
        arDone = 1;
        arvalid <= 1'b0;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (rvalid) begin
        rready <= 1'b1;
      end
    end
    @(posedge ref_clk);
  endtask : axiRead

  task automatic loadReg(input int sel, input fixed_word_t v);
    case (sel)
      0: begin
        speedStateIn <= v[15:0];
        speedStateLoad <= 1'b1;
      end
      1: begin
        speedWordIn <= v;
        speedWordLoad <= 1'b1;
      end
      2: begin
        posStateIn <= v[15:0];
        posStateLoad <= 1'b1;
      end
      3: begin
        posAngleIn <= v;
        posAngleLoad <= 1'b1;
      end
      4: begin
        emfDirectIn <= v;
        emfDirectLoad <= 1'b1;
      end
      default: begin
        emfQuadIn <= v;
        emfQuadLoad <= 1'b1;
      end
    endcase
    @(posedge ref_clk);
    {speedStateLoad, speedWordLoad, posStateLoad} <= 3'b000;
    {posAngleLoad, emfDirectLoad, emfQuadLoad} <= 3'b000;
    expVal[sel] = visible(sel, v);
  endtask : loadReg

  task automatic readCheck(input logic [10:0] idx, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(byteAddr(idx), d, r);
    check(d, e);
    check(32'(r), 32'(er));
  endtask : readCheck

  initial begin
    logic [1:0] r;
    fixed_word_t v;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      expVal[i] = '0;
      readCheck(IDX_TAB[i], 32'h00000000, `MES_RESP_OKAY);
    end
    readCheck(`MES_IDX_IRQ_STATUS, 32'h00000000, `MES_RESP_OKAY);
    for (int c = 0; c <= 6; c++) begin
      loadReg(0, 32'(c));
      readCheck(`MES_IDX_SPEED_STATE, 32'(c), `MES_RESP_OKAY);
    end
    for (int c = 0; c <= 12; c++) begin
      loadReg(2, 32'(c));
      readCheck(`MES_IDX_POS_STATE, 32'(c), `MES_RESP_OKAY);
    end
    // Every completion and fault code was loaded, so all four flags stand
    readCheck(`MES_IDX_IRQ_STATUS, 32'h0000000f, `MES_RESP_OKAY);
    check(32'(irq), 32'h0);
    // All-ones first for the 32-bit words; state codes are cut to a code below 7 or 13
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        lfsrReg = lfsrNext(lfsrReg);
        v = (k == 0) ? 32'hffffffff : lfsrReg;
        if (i == 0 || i == 2) begin
          v = visible(i, v) % ((i == 0) ? 7 : 13);
        end
        loadReg(i, v);
        readCheck(IDX_TAB[i], expVal[i], `MES_RESP_OKAY);
        lfsrReg = lfsrNext(lfsrReg);
        axiWrite(byteAddr(IDX_TAB[i]), lfsrReg, r);
        check(32'(r), 32'(`MES_RESP_OKAY));
        readCheck(IDX_TAB[i], expVal[i], `MES_RESP_OKAY);
      end
    end
    for (int i = 0; i < 6; i++) begin
      readCheck(IDX_TAB[i], expVal[i], `MES_RESP_OKAY);
    end
    readCheck(11'h000, 32'h00000000, `MES_RESP_SLVERR);
    axiWrite(byteAddr(11'h7ff), 32'h12345678, r);
    check(32'(r), 32'(`MES_RESP_SLVERR));
    axiWrite(byteAddr(`MES_IDX_IRQ_MASK), 32'h00000001, r);
    check(32'(r), 32'(`MES_RESP_OKAY));
    // Lane 0 disabled: the mask must keep its value
    strbSel = 4'he;
    axiWrite(byteAddr(`MES_IDX_IRQ_MASK), 32'h00000000, r);
    strbSel = 4'hf;
    readCheck(`MES_IDX_IRQ_MASK, 32'h00000001, `MES_RESP_OKAY);
    check(32'(irq), 32'h1);
    axiWrite(byteAddr(`MES_IDX_IRQ_STATUS), 32'h0000000f, r);
    check(32'(r), 32'(`MES_RESP_OKAY));
    repeat (2) @(posedge ref_clk);
    check(32'(irq), 32'h0);
    readCheck(`MES_IDX_IRQ_STATUS, 32'h00000000, `MES_RESP_OKAY);
    // Reset in mid-run must clear words that now hold loaded values
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      readCheck(IDX_TAB[i], 32'h00000000, `MES_RESP_OKAY);
    end
    readCheck(`MES_IDX_IRQ_MASK, 32'h00000000, `MES_RESP_OKAY);
    check(32'(irq), 32'h0);
    reportAndStop();
  end
endmodule : motor_estimator_status_regs_bench
